/* File: logic/pllcm_top.sv */
// PLL clock module control: ratio, post-divider, lock, source select and clock-fail logic.
// Assumes software ports are synchronous to i_clk_sys; oscillator clocks are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module pllcm_top
  import pllcm_pkg::*;
#(
  parameter int unsigned LOCK_CNT = LOCK_CYCLES,
  parameter int unsigned NMIWD_CNT = NMIWD_CYCLES_DEF,
  parameter int unsigned MISS_CNT = MISS_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wdog_rst,
  input wire logic i_soft_rst,
  input wire logic i_ratio_we,
  input wire logic [3:0] i_ratio_wdata,
  input wire logic i_div_we,
  input wire logic [1:0] i_div_wdata,
  input wire logic i_pll_off,
  input wire logic [1:0] i_core_src,
  input wire logic i_wdog_osc2,
  input wire logic i_tmr2_osc2,
  input wire logic i_osc1_off,
  input wire logic i_osc2_off,
  input wire logic i_ext_clock_pin_select,
  input wire logic i_ext_clock_disable,
  input wire logic i_nmi_reset_select,
  input wire logic i_nmi_ack,
  input wire logic i_internal_osc_one,
  input wire logic i_internal_osc_two,
  input wire logic i_crystal_clk,
  input wire logic i_ext_clock_pin_a,
  input wire logic i_ext_clock_pin_b,
  output logic [3:0] o_pll_ratio_register,
  output logic [1:0] o_post_divider_select,
  output logic o_pll_lock_flag,
  output logic o_pll_power_off_bit,
  output logic o_pll_powered,
  output logic o_use_multiplied,
  output logic o_limp_mode,
  output logic o_clock_fail_nmi,
  output logic o_missing_clock_status,
  output logic o_device_rst,
  output logic o_osc1_en,
  output logic o_osc2_en,
  output logic o_wdog_osc2,
  output logic o_tmr2_osc2,
  output logic [1:0] o_core_src
);
  initial begin
    if (LOCK_CNT < 1 || NMIWD_CNT < 1 || LOCK_CNT > 2**24 || NMIWD_CNT > 2**24) begin
      $error("pllcm_top: counts out of range");
    end
  end
  // ==========================================================================
  // Input clock selection and failure detection
  // ==========================================================================
  logic ext_clk;
  logic sel_clk;
  logic missing;
  // Gated external clock; held low when disabled.
  assign ext_clk = i_ext_clock_disable ? 1'b0
                 : (i_ext_clock_pin_select ? i_ext_clock_pin_b : i_ext_clock_pin_a);
  always_comb begin
    case (i_core_src)
      SRC_OSC1: sel_clk = i_internal_osc_one;
      SRC_OSC2: sel_clk = i_internal_osc_two;
      SRC_XTAL: sel_clk = i_crystal_clk;
      default: sel_clk = ext_clk;
    endcase
  end
  pllcm_clk_monitor #(.MISS_CYCLES(MISS_CNT)) u_mon (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clk_mon(sel_clk),
    .o_missing(missing)
  );
  // ==========================================================================
  // Ratio, divider, lock and mode; reset only by pin or watchdog
  // ==========================================================================
  logic cfg_rst;
  assign cfg_rst = i_rst | i_wdog_rst;
  pllcm_mode_e mode_q, mode_d;
  logic [3:0] ratio_q, ratio_d;
  logic [1:0] div_q, div_d;
  logic off_q, off_d;
  logic [24:0] lock_q, lock_d;
  logic locked_q, locked_d;
  // Next mode. A ratio write restarts locking; clearing i_pll_off does not, so o_use_multiplied returns with no lock wait.
  always_comb begin
    mode_d = mode_q;
    ratio_d = ratio_q;
    div_d = div_q;
    off_d = i_pll_off;
    lock_d = lock_q;
    locked_d = locked_q;
    if (i_div_we) begin
      div_d = i_div_wdata;
    end
    if (i_ratio_we) begin
      // Values above twelve are unsupported; they are clamped to the top ratio.
      ratio_d = (i_ratio_wdata > MULT_MAX) ? MULT_MAX : i_ratio_wdata;
      locked_d = 1'b0;
      lock_d = 25'(LOCK_CNT - 1);
      mode_d = (i_ratio_wdata == MULT_RST) ? PLLCM_BYPASS : PLLCM_LOCKING;
    end else begin
      case (mode_q)
        PLLCM_BYPASS: begin
          if (lock_q != 25'h0) lock_d = lock_q - 25'h1;
          else locked_d = 1'b1;
        end
        PLLCM_LOCKING: begin
          if (lock_q != 25'h0) begin
            lock_d = lock_q - 25'h1;
          end else begin
            locked_d = 1'b1;
            mode_d = PLLCM_ENABLED;
          end
        end
        PLLCM_ENABLED: mode_d = PLLCM_ENABLED;
        default: mode_d = PLLCM_BYPASS;
      endcase
    end
  end
  // Configuration registers; debugger and missing-clock resets do not reach them.
  always_ff @(posedge i_clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      mode_q <= PLLCM_BYPASS;
      ratio_q <= MULT_RST;
      div_q <= POST_DIVIDER_SELECT_RST;
      off_q <= 1'b0;
      lock_q <= 25'h0;
      locked_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ratio_q <= ratio_d;
      div_q <= div_d;
      off_q <= off_d;
      lock_q <= lock_d;
      locked_q <= locked_d;
    end
  end
  // ==========================================================================
  // Clock fail, NMI and NMI watchdog
  // ==========================================================================
  logic limp_q, limp_d;
  logic nmi_q, nmi_d;
  logic mcs_q, mcs_d;
  logic rst_q, rst_d;
  logic [24:0] nwd_q, nwd_d;
  logic nwd_run_q, nwd_run_d;
  logic limp_entry;
  logic fail_ok;
  // Limp mode only exists while the PLL is on, in any of the bypass, locking or enabled modes.
  assign fail_ok = ~off_q;
  assign limp_entry = missing & fail_ok & ~limp_q;
  always_comb begin
    limp_d = missing & fail_ok;
    nmi_d = nmi_q;
    mcs_d = mcs_q;
    rst_d = 1'b0;
    nwd_d = nwd_q;
    nwd_run_d = nwd_run_q;
    if (i_nmi_ack) begin
      nmi_d = 1'b0;
      nwd_run_d = 1'b0;
      nwd_d = 25'h0;
    end
    if (nwd_run_q && !i_nmi_ack) begin
      if (nwd_q >= 25'(NMIWD_CNT - 1)) begin
        rst_d = 1'b1;
        nwd_run_d = 1'b0;
        nwd_d = 25'h0;
      end else begin
        nwd_d = nwd_q + 25'h1;
      end
    end
    // Set wins over the acknowledge.
    if (limp_entry) begin
      nmi_d = 1'b1;
      mcs_d = 1'b1;
      if (i_nmi_reset_select) begin
        rst_d = 1'b1;
      end else begin
        nwd_run_d = 1'b1;
        nwd_d = 25'h0;
      end
    end
  end
  // Fail state cleared only by the pin reset, not the watchdog's; status survives the fail reset.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      limp_q <= 1'b0;
      nmi_q <= 1'b0;
      mcs_q <= 1'b0;
      rst_q <= 1'b0;
      nwd_q <= 25'h0;
      nwd_run_q <= 1'b0;
    end else begin
      limp_q <= limp_d;
      nmi_q <= nmi_d;
      mcs_q <= mcs_d;
      rst_q <= rst_d;
      nwd_q <= nwd_d;
      nwd_run_q <= nwd_run_d;
    end
  end
  // ==========================================================================
  // Output registers
  // ==========================================================================
  logic [3:0] out_ratio_q;
  logic [1:0] out_div_q, out_src_q;
  logic [8:0] out_bits_q;
  // Every top-level output is a flop copy, so the core never sees a mux glitch.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_ratio_q <= MULT_RST;
      out_div_q <= POST_DIVIDER_SELECT_RST;
      out_src_q <= SRC_RST;
      out_bits_q <= 9'h184; // both oscillators on, PLL powered in bypass.
    end else begin
      out_ratio_q <= ratio_q;
      out_div_q <= div_q;
      out_src_q <= i_core_src;
      out_bits_q <= {~i_osc1_off, ~i_osc2_off, i_wdog_osc2, i_tmr2_osc2,
                     locked_q, off_q, ~off_q,
                     (mode_q == PLLCM_ENABLED) & ~off_q & (ratio_q != MULT_RST), rst_q};
    end
  end
  assign o_pll_ratio_register = out_ratio_q;
  assign o_post_divider_select = out_div_q;
  assign o_core_src = out_src_q;
  assign o_osc1_en = out_bits_q[8];
  assign o_osc2_en = out_bits_q[7];
  assign o_wdog_osc2 = out_bits_q[6];
  assign o_tmr2_osc2 = out_bits_q[5];
  assign o_pll_lock_flag = out_bits_q[4];
  assign o_pll_power_off_bit = out_bits_q[3];
  assign o_pll_powered = out_bits_q[2];
  assign o_use_multiplied = out_bits_q[1];
  assign o_device_rst = out_bits_q[0];
  assign o_limp_mode = limp_q;
  assign o_clock_fail_nmi = nmi_q;
  assign o_missing_clock_status = mcs_q;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_wr_nonzero;
    i_ratio_we && i_ratio_wdata != 4'h0;
  endsequence
  property p_bypass_after_write;
    @(posedge i_clk_sys) disable iff (cfg_rst) s_wr_nonzero |-> ##2 !o_use_multiplied;
  endproperty
  a_bypass_after_write: assert property (p_bypass_after_write) else $error("multiplied clock too early");
  property p_lock_clears;
    @(posedge i_clk_sys) disable iff (cfg_rst) i_ratio_we |-> ##2 !o_pll_lock_flag;
  endproperty
  a_lock_clears: assert property (p_lock_clears) else $error("lock flag not cleared");
  property p_nmi_latch;
    @(posedge i_clk_sys) disable iff (i_rst) limp_entry |=> nmi_q && mcs_q;
  endproperty
  a_nmi_latch: assert property (p_nmi_latch) else $error("clock fail not latched");
  property p_mcs_sticky;
    @(posedge i_clk_sys) disable iff (i_rst) mcs_q |=> mcs_q;
  endproperty
  a_mcs_sticky: assert property (p_mcs_sticky) else $error("missing clock status lost");
  property p_immediate_rst;
    @(posedge i_clk_sys) disable iff (i_rst) limp_entry && i_nmi_reset_select |-> ##2 o_device_rst;
  endproperty
  a_immediate_rst: assert property (p_immediate_rst) else $error("no immediate reset");
  property p_no_limp_off;
    @(posedge i_clk_sys) disable iff (i_rst) $past(off_q) && off_q |-> !limp_q;
  endproperty
  a_no_limp_off: assert property (p_no_limp_off) else $error("limp while PLL off");
  property p_ext_gate;
    @(posedge i_clk_sys) disable iff (i_rst) i_ext_clock_disable |-> !ext_clk;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external clock not gated");
  property p_zero_bypass;
    @(posedge i_clk_sys) disable iff (cfg_rst) i_ratio_we && i_ratio_wdata == 4'h0 |=> mode_q == PLLCM_BYPASS;
  endproperty
  a_zero_bypass: assert property (p_zero_bypass) else $error("zero ratio not bypass");
endmodule : pllcm_top
`default_nettype wire

/* File: logic/pllcm_pkg.sv */
// Package for the PLL clock module: field widths, reset values, timing counts and modes.
// Assumes a 125 MHz system clock; all other files import it whole.
package pllcm_pkg;
  // ==========================================================================
  // Field widths and reset values
  // ==========================================================================
  localparam int unsigned MULT_W = 4;
  localparam logic [3:0] MULT_RST = 4'h0;
  localparam logic [3:0] MULT_MAX = 4'hC;
  localparam int unsigned POST_DIVIDER_SELECT_W = 2;
  localparam logic [1:0] POST_DIVIDER_SELECT_RST = 2'h0;
  localparam logic [1:0] POST_DIVIDER_SELECT_BY2 = 2'h2;
  localparam logic [1:0] POST_DIVIDER_SELECT_BY1 = 2'h3;
  localparam logic [1:0] SRC_OSC1 = 2'h0;
  localparam logic [1:0] SRC_OSC2 = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [1:0] SRC_RST = SRC_OSC1;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned LOCK_TIME_US = 1000;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int unsigned NMIWD_CYCLES_DEF = 65536;
  localparam int unsigned MISS_CYCLES_DEF = 64;
  // ==========================================================================
  // Clock path modes
  // ==========================================================================
  typedef enum logic [2:0] {
    PLLCM_BYPASS = 3'b001,
    PLLCM_LOCKING = 3'b010,
    PLLCM_ENABLED = 3'b100
  } pllcm_mode_e;
endpackage : pllcm_pkg

/* File: logic/pllcm_clk_monitor.sv */
// Missing-clock detector: watches one input clock sampled on the system clock.
// Assumes the monitored clock is slower than half the system clock.
`timescale 1ns/1ns
`default_nettype none
module pllcm_clk_monitor
  import pllcm_pkg::*;
#(
  parameter int unsigned MISS_CYCLES = MISS_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_mon,
  output logic o_missing
);
  initial begin
    if (MISS_CYCLES < 2 || MISS_CYCLES > 65535) begin
      $error("pllcm_clk_monitor: MISS_CYCLES out of range");
    end
  end
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic miss_q;
  logic miss_d;
  // Two flops synchronise, the third only serves the edge detector.
  always_comb begin
    sync_d = {sync_q[1:0], i_clk_mon};
    if (sync_q[2] != sync_q[1]) begin
      cnt_d = 16'h0000;
      miss_d = 1'b0;
    end else if (cnt_q >= 16'(MISS_CYCLES - 1)) begin
      cnt_d = cnt_q;
      miss_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h0001;
      miss_d = miss_q;
    end
  end
  // Registers of the detector.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync_q <= 3'h0;
      cnt_q <= 16'h0000;
      miss_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      miss_q <= miss_d;
    end
  end
  assign o_missing = miss_q;
endmodule : pllcm_clk_monitor
`default_nettype wire

/* File: tb/pllcm_top_test.sv */
// Self-checking bench for the PLL clock module control block, shortened counts.
// Assumes pllcm_pkg and pllcm_top are compiled first; the bench makes every clock itself.
`timescale 1ns/1ns
`default_nettype none
module pllcm_top_test
  import pllcm_pkg::*;
;
  localparam int LOCK = 20;
  localparam int NMIWD = 50;
  localparam int MISS = 16;
  logic clk, rst, wdog_rst, soft_rst, ratio_we, div_we, pll_off, wdog_osc2, tmr2_osc2;
  logic osc1_off, osc2_off, pin_sel, ext_dis, nmi_sel, nmi_ack;
  logic [3:0] ratio_wdata;
  logic [1:0] div_wdata, core_src;
  logic osc1 = 0, osc2 = 0, xtal = 0, pin_a = 0, pin_b = 0;
  logic run1 = 1, run_b = 1;
  logic [3:0] ratio;
  logic [1:0] div, src_o;
  logic lock, poff, powered, use_mult, limp, nmi, mcs, dev_rst, en1, en2, wd2, tm2;
  int error_cnt = 0, total_checks = 0, cycles = 0, n;
  pllcm_top #(.LOCK_CNT(LOCK), .NMIWD_CNT(NMIWD), .MISS_CNT(MISS)) i_pllcm_top (
    .i_clk_sys(clk), .i_rst(rst), .i_wdog_rst(wdog_rst), .i_soft_rst(soft_rst),
    .i_ratio_we(ratio_we), .i_ratio_wdata(ratio_wdata), .i_div_we(div_we),
    .i_div_wdata(div_wdata), .i_pll_off(pll_off), .i_core_src(core_src),
    .i_wdog_osc2(wdog_osc2), .i_tmr2_osc2(tmr2_osc2), .i_osc1_off(osc1_off),
    .i_osc2_off(osc2_off), .i_ext_clock_pin_select(pin_sel),
    .i_ext_clock_disable(ext_dis), .i_nmi_reset_select(nmi_sel), .i_nmi_ack(nmi_ack),
    .i_internal_osc_one(osc1), .i_internal_osc_two(osc2), .i_crystal_clk(xtal),
    .i_ext_clock_pin_a(pin_a), .i_ext_clock_pin_b(pin_b),
    .o_pll_ratio_register(ratio), .o_post_divider_select(div), .o_pll_lock_flag(lock),
    .o_pll_power_off_bit(poff), .o_pll_powered(powered), .o_use_multiplied(use_mult),
    .o_limp_mode(limp), .o_clock_fail_nmi(nmi), .o_missing_clock_status(mcs),
    .o_device_rst(dev_rst), .o_osc1_en(en1), .o_osc2_en(en2), .o_wdog_osc2(wd2),
    .o_tmr2_osc2(tm2), .o_core_src(src_o));
  // ==========================================================================
  // Clocks and watchdog
  // ==========================================================================
  // Source clocks are slow and unrelated; a stopped one stands still, as a dead one would.
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always #50 osc1 = run1 ? ~osc1 : osc1;
  always #70 osc2 = ~osc2;
  always #40 xtal = ~xtal;
  always #60 pin_a = ~pin_a;
  always #45 pin_b = run_b ? ~pin_b : pin_b;
  // The whole run needs about 550 cycles, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Outputs are read 1 ns after the edge so that edge's updates have landed.
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle
  task automatic do_reset();
    @(posedge clk);
    rst <= 1;
    core_src <= SRC_OSC1;
    pin_sel <= 0;
    ext_dis <= 0;
    nmi_sel <= 0;
    run1 = 1;
    run_b = 1;
    repeat (20) @(posedge clk);
    rst <= 0;
  endtask : do_reset
  task automatic write_ratio(input logic [3:0] v);
    @(posedge clk);
    ratio_wdata <= v;
    ratio_we <= 1;
    @(posedge clk);
    ratio_we <= 0;
  endtask : write_ratio
  task automatic write_div(input logic [1:0] v);
    @(posedge clk);
    div_wdata <= v;
    div_we <= 1;
    @(posedge clk);
    div_we <= 0;
  endtask : write_div
  task automatic wait_lock(output int k);
    k = 0;
    while (use_mult !== 1'b1 && k < 100) begin
      settle(1);
      k++;
    end
  endtask : wait_lock
  task automatic wait_fail(output int k);
    k = 0;
    while (limp !== 1'b1 && k < 100) begin
      settle(1);
      k++;
    end
  endtask : wait_fail
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_defaults();
    settle(1);
    chk_vec(ratio, MULT_RST);
    chk_vec(div, POST_DIVIDER_SELECT_RST);
    chk_bit(powered, 1);
    chk_bit(use_mult, 0);
    chk_bit(en1 & en2, 1);
    chk_vec(src_o, SRC_OSC1);
    chk_bit(limp | nmi | mcs, 0);
    settle(4);
    chk_bit(lock, 1);
  endtask : t_defaults
  task automatic t_ratio();
    write_div(0);
    write_ratio(4'h5);
    settle(2);
    chk_bit(lock, 0);
    chk_vec(ratio, 4'h5);
    chk_bit(use_mult, 0);
    wait_lock(n);
    chk_bit(n >= LOCK - 1 && n <= LOCK + 4, 1);
    chk_bit(lock, 1);
    // Back-to-back writes: the second restarts the lock wait and is clamped.
    @(posedge clk);
    ratio_wdata <= 4'h3;
    ratio_we <= 1;
    @(posedge clk);
    ratio_wdata <= 4'hF;
    @(posedge clk);
    ratio_we <= 0;
    settle(1);
    chk_bit(use_mult, 0);
    wait_lock(n);
    chk_bit(n >= LOCK - 2 && n <= LOCK + 4, 1);
    chk_vec(ratio, MULT_MAX);
    for (int i = 0; i < 4; i++) begin
      write_div(i[1:0]);
      settle(2);
      chk_vec(div, i[3:0]);
    end
    write_div(POST_DIVIDER_SELECT_RST);
    write_ratio(4'h0);
    settle(LOCK + 8);
    chk_bit(use_mult, 0);
    chk_bit(lock, 1);
  endtask : t_ratio
  task automatic t_resets();
    write_ratio(4'h7);
    wait_lock(n);
    chk_bit(use_mult, 1);
    write_div(POST_DIVIDER_SELECT_BY2);
    @(posedge clk);
    soft_rst <= 1;
    repeat (3) @(posedge clk);
    soft_rst <= 0;
    settle(2);
    chk_vec(ratio, 4'h7);
    chk_vec(div, POST_DIVIDER_SELECT_BY2);
    @(posedge clk);
    wdog_rst <= 1;
    repeat (2) @(posedge clk);
    wdog_rst <= 0;
    settle(2);
    chk_vec(ratio, 4'h0);
    chk_vec(div, POST_DIVIDER_SELECT_RST);
    chk_bit(use_mult, 0);
  endtask : t_resets
  task automatic t_pll_off();
    write_ratio(4'h0);
    @(posedge clk);
    pll_off <= 1;
    settle(3);
    chk_bit(poff, 1);
    chk_bit(powered, 0);
    settle(LOCK + 8);
    chk_bit(use_mult, 0);
    // A dead input clock while the PLL is off must not enter limp mode.
    run1 = 0;
    settle(MISS + 8);
    chk_bit(limp, 0);
    chk_bit(nmi, 0);
    run1 = 1;
    settle(14);
    @(posedge clk);
    pll_off <= 0;
    settle(3);
    chk_bit(powered, 1);
  endtask : t_pll_off
  task automatic t_select();
    @(posedge clk);
    core_src <= SRC_OSC2;
    wdog_osc2 <= 1;
    tmr2_osc2 <= 0;
    osc1_off <= 1;
    settle(3);
    chk_vec(src_o, SRC_OSC2);
    chk_bit(wd2, 1);
    chk_bit(tm2, 0);
    chk_bit(en1, 0);
    @(posedge clk);
    wdog_osc2 <= 0;
    tmr2_osc2 <= 1;
    osc1_off <= 0;
    settle(3);
    chk_bit(wd2, 0);
    chk_bit(tm2, 1);
    chk_bit(en1, 1);
    @(posedge clk);
    core_src <= SRC_OSC1;
    settle(3);
    @(posedge clk);
    tmr2_osc2 <= 0;
    osc2_off <= 1;
    settle(3);
    chk_bit(en2, 0);
    @(posedge clk);
    osc2_off <= 0;
    settle(3);
    chk_bit(en2, 1);
  endtask : t_select
  task automatic t_fail_now();
    @(posedge clk);
    nmi_sel <= 1;
    run1 = 0;
    wait_fail(n);
    chk_bit(n <= 60, 1);
    chk_bit(nmi, 1);
    chk_bit(mcs, 1);
    settle(1);
    chk_bit(dev_rst, 1);
    settle(1);
    chk_bit(dev_rst, 0);
    @(posedge clk);
    nmi_ack <= 1;
    @(posedge clk);
    nmi_ack <= 0;
    settle(1);
    chk_bit(nmi, 0);
    chk_bit(mcs, 1);
    chk_bit(limp, 1);
    do_reset();
  endtask : t_fail_now
  task automatic t_fail_wd();
    run1 = 0;
    wait_fail(n);
    chk_bit(n <= 60, 1);
    n = 0;
    while (dev_rst !== 1'b1 && n < 100) begin
      settle(1);
      n++;
    end
    chk_bit(n >= NMIWD - 3 && n <= NMIWD + 4, 1);
    do_reset();
  endtask : t_fail_wd
  task automatic t_ext();
    @(posedge clk);
    run_b = 0;
    core_src <= SRC_EXT;
    settle(60);
    chk_bit(limp, 0);
    @(posedge clk);
    pin_sel <= 1;
    wait_fail(n);
    chk_bit(n <= 60, 1);
    do_reset();
    @(posedge clk);
    core_src <= SRC_EXT;
    ext_dis <= 1;
    wait_fail(n);
    chk_bit(n <= 60, 1);
    do_reset();
  endtask : t_ext
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst = 1;
    {wdog_rst, soft_rst, ratio_we, div_we, pll_off, wdog_osc2, tmr2_osc2} = '0;
    {osc1_off, osc2_off, pin_sel, ext_dis, nmi_sel, nmi_ack} = '0;
    ratio_wdata = 4'h0;
    div_wdata = 2'h0;
    core_src = SRC_OSC1;
    repeat (20) @(posedge clk);
    rst <= 0;
    t_defaults();
    t_ratio();
    t_resets();
    t_pll_off();
    t_select();
    t_fail_now();
    t_fail_wd();
    t_ext();
    stop_test();
  end
endmodule : pllcm_top_test
`default_nettype wire
